// ### hw/cam_control_error_handler.sv
// Purpose: error detection, error code display and output safety for the cam control
// Assumes: all inputs synchronous to CLK; faults are levels, events are pulses
// Notes: highest-priority active error wins the display; serious errors hold outputs low while pending
`timescale 1ns/1ns
`include "cam_error_consts.svh"
// Function
// - acknowledging overload error blanks all outputs briefly before normal evaluation.
// - any pending serious error 100..199 holds all outputs low.
// - illegal clipped Gray encoder code each cycle raises serious error 100.
// - failed power-up checksum of non-volatile store reports error 101.
// - acknowledging checksum failure restores defaults and erases user data.
// - prohibited cam entries found at cam table init raise error 102.
// - prohibited stored configuration, e.g. resolution 127, raises error 104.
// - serial receive buffer overflow reports error 44.
// - serial transmit buffer overflow reports error 45.
// - duplicate network_node_number or faulty line reports error 42.
// - network transmit failure reports 40; receive failure reported too.
// - fieldbus device without master connection reports error 43.
// - saving an incomplete blank cam is rejected with error 46.
// - programming a prohibited direction cam is rejected with error 47.
// - option excluded by configuration is refused with error 39.
// - overload switches off only the overloaded output.
module cam_control_error_handler (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic CHECK_STROBE,
  input wire logic GRAY_VALID,
  input wire logic CHECK_DONE,
  input wire logic [15:0] RESOLUTION,
  input wire logic CONFIG_BAD,
  input wire logic FIELDBUS_PRESENT,
  input wire cam_error_pkg::fault_t FAULTS,
  input wire logic SAVE_BLANK_REQ,
  input wire logic BLANK_COMPLETE,
  input wire logic DIR_CAM_REQ,
  input wire logic DIR_CAM_ALLOWED,
  input wire logic OPTION_REQ,
  input wire logic OPTION_AVAILABLE,
  input wire logic ACK,
  input wire logic RESTORE_DONE,
  input wire logic [`NUM_OUTPUTS-1:0] CAM_IN,
  input wire logic [`NUM_OUTPUTS-1:0] OVERLOAD,
  output logic [`NUM_OUTPUTS-1:0] OUTPUTS,
  output logic [7:0] ERROR_CODE,
  output logic ERROR_ACTIVE,
  output logic SERIOUS,
  output logic REQ_REJECT,
  output logic RESTORE_DEFAULTS,
  output logic ERASE_USER
);
  // ==========================================
  // serious fault sources, error selection, display and mode state
  logic gray_bad;
  logic checksum_bad;
  logic cam_bad;
  logic config_bad;
  logic ssi_to;
  logic ssi_gray;
  logic any_serious;
  logic [7:0] next_code;
  logic next_valid;
  logic [7:0] code;
  logic overload_pending;
  logic [15:0] blank_count;
  logic [`NUM_OUTPUTS-1:0] gate_out;
  logic ack_restore;
  logic over_seen;
  cam_error_pkg::mode_t mode;

  // plausibility check latched per evaluation cycle, held until cause gone
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      gray_bad <= 1'b0;
      ssi_to <= 1'b0;
      ssi_gray <= 1'b0;
    end else if (CE && CHECK_STROBE) begin
      gray_bad <= ~GRAY_VALID | FAULTS.gray_illegal;
      ssi_to <= FAULTS.ssi_timeout;
      ssi_gray <= FAULTS.ssi_gray;
    end
  end

  // power-up checks; checksum error stays until defaults are written
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      checksum_bad <= 1'b0;
      cam_bad <= 1'b0;
      config_bad <= 1'b0;
    end else if (CE) begin
      if (CHECK_DONE) begin
        checksum_bad <= FAULTS.checksum_bad;
        cam_bad <= FAULTS.cam_prohibited;
        config_bad <= CONFIG_BAD | (RESOLUTION == `BAD_RESOLUTION);
      end else if (mode == cam_error_pkg::ST_RESTORE && RESTORE_DONE) begin
        checksum_bad <= 1'b0;
      end
    end
  end

  assign any_serious = gray_bad | ssi_to | ssi_gray | checksum_bad | cam_bad | config_bad;

  // ==========================================
  // new error selection, serious codes first
  always_comb begin
    next_valid = 1'b1;
    next_code = `ERR_NONE;
    if (gray_bad) begin
      next_code = `ERR_GRAY;
    end else if (ssi_to) begin
      next_code = `ERR_SSI_TIMEOUT;
    end else if (ssi_gray) begin
      next_code = `ERR_SSI_GRAY;
    end else if (checksum_bad && mode == cam_error_pkg::ST_POWERUP) begin
      next_code = `ERR_CHECKSUM;
    end else if (cam_bad) begin
      next_code = `ERR_CAM_INIT;
    end else if (config_bad) begin
      next_code = `ERR_CONFIG;
    end else if (|OVERLOAD && !over_seen) begin
      next_code = `ERR_OVERLOAD;
    end else if (FAULTS.net_dup_or_line) begin
      next_code = `ERR_NET_ID;
    end else if (FAULTS.net_tx_fail) begin
      next_code = `ERR_NET_TX;
    end else if (FAULTS.net_rx_fail) begin
      next_code = `ERR_NET_RX;
    end else if (FIELDBUS_PRESENT && FAULTS.fieldbus_lost) begin
      next_code = `ERR_FIELDBUS;
    end else if (FAULTS.rx_overflow) begin
      next_code = `ERR_RX_OVF;
    end else if (FAULTS.tx_overflow) begin
      next_code = `ERR_TX_OVF;
    end else if (SAVE_BLANK_REQ && !BLANK_COMPLETE) begin
      next_code = `ERR_BLANK_CAM;
    end else if (DIR_CAM_REQ && !DIR_CAM_ALLOWED) begin
      next_code = `ERR_DIR_CAM;
    end else if (OPTION_REQ && !OPTION_AVAILABLE) begin
      next_code = `ERR_CFG_OPTION;
    end else begin
      next_valid = 1'b0;
    end
  end

  // the checksum error re-reports itself at power-up, so its own ack must not be overridden
  assign ack_restore = ACK && (mode == cam_error_pkg::ST_POWERUP)
                     && (next_code == `ERR_CHECKSUM);

  // overload reported once per episode, re-armed when all overloads clear
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      over_seen <= 1'b0;
    end else if (CE) begin
      over_seen <= |OVERLOAD;
    end
  end

  // ==========================================
  // displayed error: new error beats acknowledge in the same cycle
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      code <= `ERR_NONE;
    end else if (CE) begin
      if (next_valid && !ack_restore) begin
        code <= next_code;
      end else if (ACK) begin
        code <= `ERR_NONE;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ERROR_CODE <= `ERR_NONE;
      ERROR_ACTIVE <= 1'b0;
      SERIOUS <= 1'b0;
    end else if (CE) begin
      ERROR_CODE <= code;
      ERROR_ACTIVE <= (code != `ERR_NONE);
      SERIOUS <= (code >= `SERIOUS_LO) && (code <= `SERIOUS_HI);
    end
  end

  // command rejection pulse for refused programming requests
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      REQ_REJECT <= 1'b0;
    end else if (CE) begin
      REQ_REJECT <= (SAVE_BLANK_REQ && !BLANK_COMPLETE)
                  | (DIR_CAM_REQ && !DIR_CAM_ALLOWED)
                  | (OPTION_REQ && !OPTION_AVAILABLE);
    end
  end

  assign overload_pending = (code == `ERR_OVERLOAD);

  // ==========================================
  // mode machine: power-up, run, blanking, restoring defaults
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      mode <= cam_error_pkg::ST_POWERUP;
      blank_count <= 16'h0000;
    end else if (CE) begin
      case (mode)
        cam_error_pkg::ST_POWERUP: begin
          if (ack_restore) begin
            mode <= cam_error_pkg::ST_RESTORE;
          end else if (CHECK_DONE && !FAULTS.checksum_bad) begin
            mode <= cam_error_pkg::ST_RUN;
          end
        end
        cam_error_pkg::ST_RUN: begin
          if (overload_pending && ACK && !next_valid) begin
            mode <= cam_error_pkg::ST_BLANK;
            blank_count <= 16'(`BLANK_CYCLES - 1);
          end
        end
        cam_error_pkg::ST_BLANK: begin
          if (blank_count == 16'h0000) begin
            mode <= cam_error_pkg::ST_RUN;
          end else begin
            blank_count <= blank_count - 16'h0001;
          end
        end
        cam_error_pkg::ST_RESTORE: begin
          if (RESTORE_DONE) begin
            mode <= cam_error_pkg::ST_RUN;
          end
        end
        default: begin
          mode <= cam_error_pkg::ST_POWERUP;
        end
      endcase
    end
  end

  // restore and erase commands held while restoring
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      RESTORE_DEFAULTS <= 1'b0;
      ERASE_USER <= 1'b0;
    end else if (CE) begin
      RESTORE_DEFAULTS <= (mode == cam_error_pkg::ST_RESTORE) && !RESTORE_DONE;
      ERASE_USER <= (mode == cam_error_pkg::ST_RESTORE) && !RESTORE_DONE;
    end
  end

  // ==========================================
  // output gating; outputs dead until the checks have passed
  output_gate u_gate (
    .clk(CLK),
    .reset_n(RESET_N),
    .ce(CE),
    .force_low(any_serious | (mode != cam_error_pkg::ST_RUN)),
    .ack(ACK),
    .cam_in(CAM_IN),
    .overload(OVERLOAD),
    .out(gate_out),
    .off()
  );

  // extra register stage keeps outputs strictly registered at the top
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      OUTPUTS <= '0;
    end else if (CE) begin
      OUTPUTS <= (mode == cam_error_pkg::ST_BLANK) ? '0 : gate_out;
    end
  end
endmodule : cam_control_error_handler

// ### pkg/cam_error_consts.svh
// Purpose: constants for the cam control error handler
// Assumes: 20 MHz clock
// Notes: error codes are decimal numbers held in 8 bits
`ifndef CAM_ERROR_CONSTS_SVH
`define CAM_ERROR_CONSTS_SVH
`define ERR_NONE 8'h00
`define ERR_CFG_OPTION 8'h27
`define ERR_NET_TX 8'h28
`define ERR_NET_RX 8'h29
`define ERR_NET_ID 8'h2a
`define ERR_FIELDBUS 8'h2b
`define ERR_RX_OVF 8'h2c
`define ERR_TX_OVF 8'h2d
`define ERR_BLANK_CAM 8'h2e
`define ERR_DIR_CAM 8'h2f
`define ERR_OVERLOAD 8'h1f
`define ERR_GRAY 8'h64
`define ERR_CHECKSUM 8'h65
`define ERR_CAM_INIT 8'h66
`define ERR_CONFIG 8'h68
`define ERR_SSI_TIMEOUT 8'h6c
`define ERR_SSI_GRAY 8'h6f
`define SERIOUS_LO 8'h64
`define SERIOUS_HI 8'hc7
`define BAD_RESOLUTION 16'h007f
`define BLANK_TIME_US 10
`define CLK_MHZ 20
`define BLANK_CYCLES ((`BLANK_TIME_US) * (`CLK_MHZ))
`define NUM_OUTPUTS 16
`endif

// ### pkg/cam_error_pkg.sv
// Purpose: types for the cam control error handler
// Assumes: nothing
// Notes: fault inputs travel as one packed struct
package cam_error_pkg;
  typedef logic [7:0] err_code_t;
  typedef struct packed {
    logic gray_illegal;
    logic ssi_timeout;
    logic ssi_gray;
    logic checksum_bad;
    logic cam_prohibited;
    logic net_dup_or_line;
    logic net_tx_fail;
    logic net_rx_fail;
    logic fieldbus_lost;
    logic rx_overflow;
    logic tx_overflow;
  } fault_t;
  typedef enum logic [1:0] {ST_POWERUP, ST_RUN, ST_BLANK, ST_RESTORE} mode_t;
endpackage : cam_error_pkg

// ### hw/output_gate.sv
// Purpose: per-output gating of cam outputs
// Assumes: overload latch cleared by acknowledge
// Notes: one generate loop, two flops per output
`timescale 1ns/1ns
`include "cam_error_consts.svh"
module output_gate (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic force_low,
  input wire logic ack,
  input wire logic [`NUM_OUTPUTS-1:0] cam_in,
  input wire logic [`NUM_OUTPUTS-1:0] overload,
  output logic [`NUM_OUTPUTS-1:0] out,
  output logic [`NUM_OUTPUTS-1:0] off
);
  // ==========================================
  // per-output overload latch and output flop
  genvar i;
  generate
    for (i = 0; i < `NUM_OUTPUTS; i = i + 1) begin : g_out
      // set wins over acknowledge so a live overload stays off
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          off[i] <= 1'b0;
        end else if (ce) begin
          if (overload[i]) begin
            off[i] <= 1'b1;
          end else if (ack) begin
            off[i] <= 1'b0;
          end
        end
      end
      // only the overloaded output drops
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          out[i] <= 1'b0;
        end else if (ce) begin
          out[i] <= cam_in[i] & ~off[i] & ~overload[i] & ~force_low;
        end
      end
    end
  endgenerate
endmodule : output_gate

// ### test/enc_model.sv
// Purpose: absolute encoder link model
// Assumes: read mode chosen by the bench
// Notes: flags only, no position data
`timescale 1ns/1ns
module enc_model (
  input wire logic [1:0] mode,
  output logic gray_valid,
  output logic [2:0] flags
);
  // ==========
  // 1 illegal code, 2 link timeout, 3 link code error
  assign gray_valid = (mode != 2'h1);
  assign flags = {mode == 2'h1, mode == 2'h2, mode == 2'h3};
endmodule : enc_model

// ### test/cam_err_props.sv
// Purpose: port checks for the error handler
// Assumes: one clock, sync active-low reset
// Notes: windows follow the hand-over latencies
`timescale 1ns/1ns
`include "cam_error_consts.svh"
module cam_err_props (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic CHECK_STROBE,
  input wire logic GRAY_VALID,
  input wire cam_error_pkg::fault_t FAULTS,
  input wire logic FIELDBUS_PRESENT,
  input wire logic SAVE_BLANK_REQ,
  input wire logic BLANK_COMPLETE,
  input wire logic ACK,
  input wire logic [`NUM_OUTPUTS-1:0] OVERLOAD,
  input wire logic [`NUM_OUTPUTS-1:0] OUTPUTS,
  input wire logic [7:0] ERROR_CODE,
  input wire logic REQ_REJECT,
  input wire logic RESTORE_DEFAULTS,
  input wire logic ERASE_USER
);
  // ==========
  // shared sequences
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  sequence s_bad_gray;
    CE && CHECK_STROBE && !GRAY_VALID;
  endsequence
  sequence s_ack31;
    CE && ACK && ERROR_CODE == `ERR_OVERLOAD && OVERLOAD == 16'h0000;
  endsequence
  // ==========
  // checks
  a_serious_low: assert property (
    s_bad_gray ##1 (!CHECK_STROBE) [*4] |-> OUTPUTS == 16'h0000)
    else $error("outputs live after bad read");
  a_gray_code: assert property (
    s_bad_gray |-> ##[1:4] ERROR_CODE == `ERR_GRAY)
    else $error("no gray error code");
  a_ssi_timeout: assert property (
    CHECK_STROBE && GRAY_VALID && FAULTS == 11'h200 |-> ##[1:4] ERROR_CODE == `ERR_SSI_TIMEOUT)
    else $error("no link timeout code");
  a_restore_pair: assert property (
    RESTORE_DEFAULTS |-> ERASE_USER)
    else $error("restore without erase");
  a_overload_one: assert property (
    OVERLOAD[0] [*3] |=> !OUTPUTS[0])
    else $error("overloaded output still on");
  a_blank_on_ack: assert property (
    s_ack31 |-> ##3 (OUTPUTS == 16'h0000) [*5])
    else $error("no blanking after acknowledge");
  a_fieldbus_code: assert property (
    (FIELDBUS_PRESENT && FAULTS == 11'h004) [*3] |-> ERROR_CODE == `ERR_FIELDBUS)
    else $error("no fieldbus code");
  a_blank_reject: assert property (
    CE && SAVE_BLANK_REQ && !BLANK_COMPLETE |-> ##[1:2] REQ_REJECT)
    else $error("blank save not rejected");
endmodule : cam_err_props

// ### test/cam_control_error_handler_tb.sv
// Purpose: self-checking bench for the error handler
// Assumes: fixed answer latency and 200-cycle blank
// Notes: waits are fixed counts from that latency
`timescale 1ns/1ns
`include "cam_error_consts.svh"
module cam_control_error_handler_tb;
  // ==========
  // signals
  logic CLK, RESET_N, CE, CHECK_STROBE, CHECK_DONE, CONFIG_BAD;
  logic FIELDBUS_PRESENT, ACK, RESTORE_DONE, hit;
  logic [15:0] RESOLUTION, CAM_IN, OVERLOAD, OUTPUTS;
  logic [7:0] ERROR_CODE, flt;
  logic ERROR_ACTIVE, SERIOUS, REQ_REJECT, RESTORE_DEFAULTS, ERASE_USER;
  logic [2:0] req, ok, encf;
  logic [1:0] emode;
  logic [7:0] code [6];
  wire GRAY_VALID;
  wire SAVE_BLANK_REQ = req[2], DIR_CAM_REQ = req[1], OPTION_REQ = req[0];
  wire BLANK_COMPLETE = ok[2], DIR_CAM_ALLOWED = ok[1], OPTION_AVAILABLE = ok[0];
  cam_error_pkg::fault_t FAULTS;
  int num_errors = 0, n_tests = 0, n_cyc = 0;
  assign FAULTS = {encf, flt};
  enc_model u_enc_model (.mode(emode), .gray_valid(GRAY_VALID), .flags(encf));
  cam_control_error_handler u_cam_control_error_handler (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .CE(CE),
    .CHECK_STROBE(CHECK_STROBE),
    .GRAY_VALID(GRAY_VALID),
    .CHECK_DONE(CHECK_DONE),
    .RESOLUTION(RESOLUTION),
    .CONFIG_BAD(CONFIG_BAD),
    .FIELDBUS_PRESENT(FIELDBUS_PRESENT),
    .FAULTS(FAULTS),
    .SAVE_BLANK_REQ(SAVE_BLANK_REQ),
    .BLANK_COMPLETE(BLANK_COMPLETE),
    .DIR_CAM_REQ(DIR_CAM_REQ),
    .DIR_CAM_ALLOWED(DIR_CAM_ALLOWED),
    .OPTION_REQ(OPTION_REQ),
    .OPTION_AVAILABLE(OPTION_AVAILABLE),
    .ACK(ACK),
    .RESTORE_DONE(RESTORE_DONE),
    .CAM_IN(CAM_IN),
    .OVERLOAD(OVERLOAD),
    .OUTPUTS(OUTPUTS),
    .ERROR_CODE(ERROR_CODE),
    .ERROR_ACTIVE(ERROR_ACTIVE),
    .SERIOUS(SERIOUS),
    .REQ_REJECT(REQ_REJECT),
    .RESTORE_DEFAULTS(RESTORE_DEFAULTS),
    .ERASE_USER(ERASE_USER)
  );
  // ==========
  // helpers
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : cyc
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // pulses clear their qualifiers with the strobe
  task strobe(input logic [1:0] m);
    @(posedge CLK);
    emode <= m;
    CHECK_STROBE <= 1'b1;
    @(posedge CLK);
    emode <= 2'h0;
    CHECK_STROBE <= 1'b0;
    cyc(5);
  endtask : strobe
  task done(input logic [7:0] f, input logic cb, input logic [15:0] res);
    @(posedge CLK);
    {flt, CONFIG_BAD, RESOLUTION, CHECK_DONE} <= {f, cb, res, 1'b1};
    @(posedge CLK);
    {flt, CONFIG_BAD, RESOLUTION, CHECK_DONE} <= {8'h00, 1'b0, 16'h0400, 1'b0};
    cyc(5);
  endtask : done
  task ack_pulse;
    @(posedge CLK);
    ACK <= 1'b1;
    @(posedge CLK);
    ACK <= 1'b0;
    cyc(4);
  endtask : ack_pulse
  // ==========
  // scenarios
  task t_checksum;
    done(8'h80, 1'b0, 16'h0400);
    chk({ERROR_ACTIVE, ERROR_CODE, OUTPUTS}, {1'b1, `ERR_CHECKSUM, 16'h0000});
    ack_pulse;
    chk({RESTORE_DEFAULTS, ERASE_USER}, 2'h3);
    @(posedge CLK);
    RESTORE_DONE <= 1'b1;
    @(posedge CLK);
    RESTORE_DONE <= 1'b0;
    cyc(4);
    chk({RESTORE_DEFAULTS, ERASE_USER, ERROR_CODE, OUTPUTS}, {10'h000, CAM_IN});
  endtask : t_checksum
  task t_encoder;
    code = '{`ERR_GRAY, `ERR_SSI_TIMEOUT, `ERR_SSI_GRAY, 8'h00, 8'h00, 8'h00};
    for (int m = 1; m < 4; m++) begin
      strobe(m[1:0]);
      chk({SERIOUS, ERROR_CODE, OUTPUTS}, {1'b1, code[m-1], 16'h0000});
      strobe(2'h0);
      chk(OUTPUTS, CAM_IN);
      ack_pulse;
      chk(ERROR_CODE, 8'h00);
    end
  endtask : t_encoder
  task t_config;
    for (int i = 0; i < 3; i++) begin
      done({1'b0, i == 0, 6'h00}, i == 2, (i == 1) ? 16'h007f : 16'h0400);
      chk({ERROR_CODE, OUTPUTS}, {(i == 0) ? `ERR_CAM_INIT : `ERR_CONFIG, 16'h0000});
      done(8'h00, 1'b0, 16'h0400);
      ack_pulse;
      chk(ERROR_CODE, 8'h00);
    end
  endtask : t_config
  // levels hold the code through an early acknowledge
  task t_levels;
    code = '{`ERR_NET_ID, `ERR_NET_TX, `ERR_NET_RX, `ERR_FIELDBUS, `ERR_RX_OVF, `ERR_TX_OVF};
    for (int i = 0; i < 6; i++) begin
      @(posedge CLK);
      flt <= 8'h20 >> i;
      ack_pulse;
      chk({ERROR_CODE, OUTPUTS}, {code[i], CAM_IN});
      @(posedge CLK);
      flt <= 8'h00;
      ack_pulse;
      chk(ERROR_CODE, 8'h00);
    end
    // no fieldbus fitted: a lost master is not an error
    @(posedge CLK);
    FIELDBUS_PRESENT <= 1'b0;
    flt <= 8'h04;
    cyc(4);
    chk(ERROR_CODE, 8'h00);
    @(posedge CLK);
    FIELDBUS_PRESENT <= 1'b1;
    flt <= 8'h00;
    cyc(2);
  endtask : t_levels
  // low enable freezes the display; the fault is taken once it rises
  task t_freeze;
    @(posedge CLK);
    CE <= 1'b0;
    flt <= 8'h20;
    cyc(4);
    chk({ERROR_ACTIVE, ERROR_CODE}, 9'h000);
    @(posedge CLK);
    CE <= 1'b1;
    cyc(3);
    chk({ERROR_ACTIVE, ERROR_CODE}, {1'b1, `ERR_NET_ID});
    @(posedge CLK);
    flt <= 8'h00;
    ack_pulse;
    chk(ERROR_CODE, 8'h00);
  endtask : t_freeze
  task t_reqs;
    code = '{`ERR_BLANK_CAM, `ERR_DIR_CAM, `ERR_CFG_OPTION, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      hit = 1'b0;
      @(posedge CLK);
      req <= 3'h4 >> (i % 3);
      ok <= {3{i > 2}};
      @(posedge CLK);
      req <= 3'h0;
      #1;
      hit = REQ_REJECT; // the one-cycle pulse stands from this edge only
      repeat (4) begin
        @(posedge CLK);
        #1;
        hit = hit | REQ_REJECT;
      end
      chk({hit, ERROR_CODE}, (i < 3) ? {1'b1, code[i]} : 9'h000);
      ack_pulse;
    end
  endtask : t_reqs
  task t_overload;
    @(posedge CLK);
    OVERLOAD <= 16'h0001;
    cyc(4);
    chk({ERROR_CODE, OUTPUTS}, {`ERR_OVERLOAD, CAM_IN & 16'hfffe});
    @(posedge CLK);
    OVERLOAD <= 16'h0000;
    ack_pulse;
    chk(OUTPUTS, 16'h0000);
    cyc(180);
    chk(OUTPUTS, 16'h0000);
    cyc(30);
    chk({ERROR_CODE, OUTPUTS}, {8'h00, CAM_IN});
  endtask : t_overload
  // ==========
  // clock, hang guard, main sequence
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 3000) begin
      num_errors++;
      give_verdict;
    end
  end
  initial begin
    RESET_N = 1'b0;
    {CE, FIELDBUS_PRESENT} = 2'b11;
    {CHECK_STROBE, CHECK_DONE, CONFIG_BAD, ACK, RESTORE_DONE} = 5'h00;
    {flt, req, ok, emode} = 16'h0000;
    {RESOLUTION, CAM_IN, OVERLOAD} = {16'h0400, 16'ha5c3, 16'h0000};
    repeat (10) @(posedge CLK);
    RESET_N <= 1'b1;
    cyc(1);
    t_checksum;
    t_encoder;
    t_config;
    t_levels;
    t_freeze;
    t_reqs;
    t_overload;
    give_verdict;
  end
endmodule : cam_control_error_handler_tb
bind cam_control_error_handler cam_err_props u_cam_err_props (
  .CLK(CLK),
  .RESET_N(RESET_N),
  .CE(CE),
  .CHECK_STROBE(CHECK_STROBE),
  .GRAY_VALID(GRAY_VALID),
  .FAULTS(FAULTS),
  .FIELDBUS_PRESENT(FIELDBUS_PRESENT),
  .SAVE_BLANK_REQ(SAVE_BLANK_REQ),
  .BLANK_COMPLETE(BLANK_COMPLETE),
  .ACK(ACK),
  .OVERLOAD(OVERLOAD),
  .OUTPUTS(OUTPUTS),
  .ERROR_CODE(ERROR_CODE),
  .REQ_REJECT(REQ_REJECT),
  .RESTORE_DEFAULTS(RESTORE_DEFAULTS),
  .ERASE_USER(ERASE_USER)
);
